/* verilog/bpo_port.sv */
// bcd pressure output port with keypad settings and apb access
// Behaviour
// - mantissa out as three positive-true bcd digits: units, tenths, hundredths
// - exponent out as sign (high plus), tens bit and bcd units digit
// - strobe low while stable, high about 10 us twice a second to update
// - float request high puts all data lines in high impedance
// - freeze input low blocks data updates until it returns high
// - undriven control inputs read as high
// - card carries one display group chosen by jumper
// - convection source without that option outputs unit maximum
// - code 0 restores each card source to its group ion gauge
// - sources: ion, convection, system, display pressure
// - code 5 and 6 select group source; select cycles, enter commits
// - settings change only while security indicator is green
// - codes 24,25,26 set torr, millibar, pascal and light indicator
// - code 0 returns unit to torr
// - enter shows current setting; enter again leaves it unchanged
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module bpo_port #(
    parameter int UPDATE_CYC = bpo_pkg::UPDATE_CYC
) (
    input  wire logic                          clock_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          psel_i,
    input  wire logic                          penable_i,
    input  wire logic                          pwrite_i,
    input  wire logic [7:0]                    paddr_i,
    input  wire logic [31:0]                   pwdata_i,
    output logic      [31:0]                   prdata_o,
    output logic                               pready_o,
    output logic                               pslverr_o,
    input  wire logic                          float_req_i,
    input  wire logic                          hold_n_i,
    input  wire logic                          group_jumper_i,
    input  wire logic                          security_green_i,
    input  wire logic                          cg_installed_i,
    input  wire logic [1:0]                    ion_gauge_on_i,
    input  wire bpo_pkg::bpo_press_t [1:0]     ion_press_i,
    input  wire bpo_pkg::bpo_press_t [1:0]     conv_press_i,
    input  wire bpo_pkg::bpo_press_t [1:0]     disp_press_i,
    output bpo_pkg::bpo_press_t                press_o,
    output logic                               press_oe_o,
    output logic                               strobe_o,
    output logic [2:0]                         unit_ind_o,
    output logic                               irq_o
);

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == bpo_pkg::OFS_CMD) || (a == bpo_pkg::OFS_SETTING)
               || (a == bpo_pkg::OFS_STATUS) || (a == bpo_pkg::OFS_MASK)
               || (a == bpo_pkg::OFS_SAMPLE);
    endfunction : reg_hit

    // pin synchronisers: float, hold, jumper
    localparam int NPIN = 3;
    logic [NPIN-1:0]     pin_raw;
    logic [NPIN-1:0]     pin_q;
    assign pin_raw = {group_jumper_i, hold_n_i, float_req_i};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            logic [2:0] sh_reg;
            logic       filt_reg;
            // resets high: an open control pin is pulled up
            always_ff @(posedge clock_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    sh_reg   <= 3'h7;
                    filt_reg <= 1'b1;
                end
                else
                begin
                    sh_reg <= {sh_reg[1:0], pin_raw[gi]};
                    if (sh_reg[1] == sh_reg[2])
                        filt_reg <= sh_reg[2];
                end
            end
            assign pin_q[gi] = filt_reg;
        end
    endgenerate

    logic float_q;
    logic hold_q;
    logic group_q;
    assign float_q = pin_q[0];
    assign hold_q  = pin_q[1];
    assign group_q = pin_q[2];

    // apb decode
    logic        acc;
    logic        wr;
    logic        wr_cmd;
    logic [1:0]  key;
    logic [4:0]  code_in;
    assign acc     = psel_i && penable_i;
    assign wr      = acc && pwrite_i;
    assign wr_cmd  = wr && (paddr_i == bpo_pkg::OFS_CMD);
    assign key     = pwdata_i[bpo_pkg::CMD_KEY_LSB +: 2];
    assign code_in = pwdata_i[bpo_pkg::CMD_CODE_LSB +: 5];
    assign pready_o  = 1'b1;
    assign pslverr_o = acc && !reg_hit(paddr_i);

    // keypad state
    bpo_pkg::bpo_kp_t   kp_reg;
    logic [4:0]         code_reg;
    bpo_pkg::bpo_src_t  pend_reg;
    bpo_pkg::bpo_unit_t unit_reg;
    bpo_pkg::bpo_src_t  src_reg [2];

    logic enter_code;
    logic enter_show;
    logic code_unit;
    logic code_fact;
    logic src_g;
    logic do_factory;
    logic do_unit;
    logic do_src;
    logic reject;

    assign enter_code = wr_cmd && key == bpo_pkg::KEY_ENTER
                     && kp_reg == bpo_pkg::KP_CODE;
    assign enter_show = wr_cmd && key == bpo_pkg::KEY_ENTER
                     && kp_reg == bpo_pkg::KP_SHOW;
    assign code_unit  = code_reg == bpo_pkg::FC_TORR
                     || code_reg == bpo_pkg::FC_MBAR
                     || code_reg == bpo_pkg::FC_PASCAL;
    assign code_fact  = code_reg == bpo_pkg::FC_FACTORY;
    assign src_g      = code_reg == bpo_pkg::FC_SRC_G2;
    // every change is gated by the security indicator
    assign do_factory = enter_code && code_fact && security_green_i;
    assign do_unit    = enter_code && code_unit && security_green_i;
    assign do_src     = enter_show && security_green_i;
    assign reject     = (enter_code && (code_fact || code_unit)
                         && !security_green_i)
                     || (enter_show && !security_green_i
                         && pend_reg != src_reg[src_g]);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            kp_reg   <= bpo_pkg::KP_IDLE;
            code_reg <= bpo_pkg::FC_FACTORY;
            pend_reg <= bpo_pkg::SRC_ION;
        end
        else if (wr_cmd)
        begin
            unique case (key)
                bpo_pkg::KEY_DIGITS:
                begin
                    code_reg <= code_in;
                    kp_reg   <= bpo_pkg::KP_CODE;
                end
                bpo_pkg::KEY_SELECT:
                begin
                    // select cycles the four sources
                    if (kp_reg == bpo_pkg::KP_SHOW)
                        pend_reg <= bpo_pkg::bpo_src_t'(pend_reg + 2'h1);
                end
                bpo_pkg::KEY_ENTER:
                begin
                    if (kp_reg == bpo_pkg::KP_CODE
                        && (code_reg == bpo_pkg::FC_SRC_G1 || src_g))
                    begin
                        // show what is programmed now
                        pend_reg <= src_reg[src_g];
                        kp_reg   <= bpo_pkg::KP_SHOW;
                    end
                    else
                        kp_reg <= bpo_pkg::KP_IDLE;
                end
                default:
                    kp_reg <= kp_reg;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            unit_reg <= bpo_pkg::UNIT_TORR;
        else if (do_factory)
            unit_reg <= bpo_pkg::UNIT_TORR;
        else if (do_unit)
        begin
            unique case (code_reg)
                bpo_pkg::FC_MBAR:   unit_reg <= bpo_pkg::UNIT_MBAR;
                bpo_pkg::FC_PASCAL: unit_reg <= bpo_pkg::UNIT_PA;
                default:            unit_reg <= bpo_pkg::UNIT_TORR;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            src_reg[0] <= bpo_pkg::SRC_ION;
            src_reg[1] <= bpo_pkg::SRC_ION;
        end
        else if (do_factory)
        begin
            src_reg[0] <= bpo_pkg::SRC_ION;
            src_reg[1] <= bpo_pkg::SRC_ION;
        end
        else if (do_src)
            src_reg[src_g] <= pend_reg; // unchanged if no select
    end

    always_comb
    begin
        unit_ind_o = 3'h0;
        unit_ind_o[unit_reg] = 1'b1;
    end

    // source mux for the jumper-chosen group
    bpo_pkg::bpo_src_t  eff_src;
    bpo_pkg::bpo_press_t max_p;
    bpo_pkg::bpo_press_t sel_p;
    assign eff_src = src_reg[group_q];

    always_comb
    begin
        unique case (unit_reg)
            bpo_pkg::UNIT_MBAR: max_p = bpo_pkg::MAX_MBAR;
            bpo_pkg::UNIT_PA:   max_p = bpo_pkg::MAX_PA;
            default:            max_p = bpo_pkg::MAX_TORR;
        endcase
    end

    always_comb
    begin
        sel_p = ion_press_i[group_q];
        unique case (eff_src)
            bpo_pkg::SRC_ION:  sel_p = ion_press_i[group_q];
            bpo_pkg::SRC_CONV: sel_p = conv_press_i[group_q];
            bpo_pkg::SRC_SYS:  sel_p = ion_gauge_on_i[group_q]
                                     ? ion_press_i[group_q]
                                     : conv_press_i[group_q];
            bpo_pkg::SRC_DISP: sel_p = disp_press_i[group_q];
        endcase
        // missing convection option reads as full scale
        if (!cg_installed_i && (eff_src == bpo_pkg::SRC_CONV
            || (eff_src == bpo_pkg::SRC_SYS && !ion_gauge_on_i[group_q])))
            sel_p = max_p;
    end

    // update timing
    logic [bpo_pkg::PER_W-1:0] per_cnt;
    logic [bpo_pkg::STR_W-1:0] str_cnt;
    logic                      strobe_reg;
    logic                      tick;
    logic                      load;
    bpo_pkg::bpo_press_t       press_reg;

    assign tick = per_cnt == bpo_pkg::PER_W'(UPDATE_CYC - 1);
    // load one cycle into the pulse, so data never moves while low
    assign load = strobe_reg && str_cnt == '0 && hold_q;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            per_cnt <= '0;
        else if (tick)
            per_cnt <= '0;
        else
            per_cnt <= per_cnt + 1'b1;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            strobe_reg <= 1'b0;
            str_cnt    <= '0;
        end
        else if (strobe_reg)
        begin
            if (str_cnt == bpo_pkg::STR_W'(bpo_pkg::STROBE_CYC - 1))
            begin
                strobe_reg <= 1'b0;
                str_cnt    <= '0;
            end
            else
                str_cnt <= str_cnt + 1'b1;
        end
        else if (tick && hold_q)
            strobe_reg <= 1'b1; // no pulse while frozen
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            press_reg <= bpo_pkg::PRESS_RST;
        else if (load)
            press_reg <= sel_p;
    end

    assign press_o    = press_reg;
    assign strobe_o   = strobe_reg;
    assign press_oe_o = !float_q;

    // interrupts: set wins over write-one-to-clear
    logic [bpo_pkg::ST_W-1:0] status_reg;
    logic [bpo_pkg::ST_W-1:0] mask_reg;
    logic [bpo_pkg::ST_W-1:0] events;
    logic [bpo_pkg::ST_W-1:0] clr;

    always_comb
    begin
        events = '0;
        events[bpo_pkg::ST_UPDATE] = load;
        events[bpo_pkg::ST_HELD]   = tick && !hold_q;
        events[bpo_pkg::ST_REJECT] = reject;
        clr = '0;
        if (wr && paddr_i == bpo_pkg::OFS_STATUS)
            clr = pwdata_i[bpo_pkg::ST_W-1:0];
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            status_reg <= bpo_pkg::ST_RST;
        else
            status_reg <= (status_reg & ~clr) | events;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            mask_reg <= bpo_pkg::ST_RST;
        else if (wr && paddr_i == bpo_pkg::OFS_MASK)
            mask_reg <= pwdata_i[bpo_pkg::ST_W-1:0];
    end

    assign irq_o = |(status_reg & mask_reg);

    // read data captured in the setup phase
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            bpo_pkg::OFS_SETTING:
            begin
                rd_mux[bpo_pkg::SET_UNIT_LSB +: 2] = unit_reg;
                rd_mux[bpo_pkg::SET_SRC1_LSB +: 2] = src_reg[0];
                rd_mux[bpo_pkg::SET_SRC2_LSB +: 2] = src_reg[1];
                rd_mux[bpo_pkg::SET_PEND_LSB +: 2] = pend_reg;
                rd_mux[bpo_pkg::SET_KP_LSB +: 3]   = kp_reg;
            end
            bpo_pkg::OFS_STATUS: rd_mux[bpo_pkg::ST_W-1:0] = status_reg;
            bpo_pkg::OFS_MASK:   rd_mux[bpo_pkg::ST_W-1:0] = mask_reg;
            bpo_pkg::OFS_SAMPLE: rd_mux[$bits(press_reg)-1:0] = press_reg;
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            prdata_reg <= 32'h0000_0000;
        else if (psel_i && !penable_i)
            prdata_reg <= rd_mux;
    end

    assign prdata_o = prdata_reg;

    // checks
    property p_strobe_width;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(strobe_o) |-> strobe_o [*8] ##0
            (str_cnt == bpo_pkg::STR_W'(7));
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe pulse too short");

    property p_strobe_end;
        @(posedge clock_i) disable iff (!rst_b_i)
        $fell(strobe_o) |->
            $past(str_cnt) == bpo_pkg::STR_W'(bpo_pkg::STROBE_CYC - 1);
    endproperty
    a_strobe_end: assert property (p_strobe_end)
        else $error("strobe width wrong");

    property p_stable_low;
        @(posedge clock_i) disable iff (!rst_b_i)
        (!strobe_o && !$past(strobe_o)) |-> $stable(press_o);
    endproperty
    a_stable_low: assert property (p_stable_low)
        else $error("data moved while strobe low");

    property p_float;
        @(posedge clock_i) disable iff (!rst_b_i)
        float_req_i [*4] |=> !press_oe_o;
    endproperty
    a_float: assert property (p_float)
        else $error("float request not honoured");

    property p_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        !hold_q |=> $stable(press_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("data updated while frozen");

    property p_factory;
        @(posedge clock_i) disable iff (!rst_b_i)
        do_factory |=> unit_reg == bpo_pkg::UNIT_TORR
            && src_reg[0] == bpo_pkg::SRC_ION
            && src_reg[1] == bpo_pkg::SRC_ION && unit_ind_o == 3'h1;
    endproperty
    a_factory: assert property (p_factory)
        else $error("factory restore incomplete");

    property p_secure;
        @(posedge clock_i) disable iff (!rst_b_i)
        !security_green_i |=> $stable(unit_reg) && $stable(src_reg[0])
            && $stable(src_reg[1]);
    endproperty
    a_secure: assert property (p_secure)
        else $error("setting changed while secured");

    property p_pascal;
        @(posedge clock_i) disable iff (!rst_b_i)
        (do_unit && code_reg == bpo_pkg::FC_PASCAL)
            |=> unit_reg == bpo_pkg::UNIT_PA && unit_ind_o == 3'h4;
    endproperty
    a_pascal: assert property (p_pascal)
        else $error("pascal unit not set");

    property p_cg_max;
        @(posedge clock_i) disable iff (!rst_b_i)
        (load && !cg_installed_i && eff_src == bpo_pkg::SRC_CONV)
            |=> press_o == $past(max_p);
    endproperty
    a_cg_max: assert property (p_cg_max)
        else $error("missing gauge not at maximum");

    property p_show;
        @(posedge clock_i) disable iff (!rst_b_i)
        (enter_code && code_reg == bpo_pkg::FC_SRC_G2)
            |=> kp_reg == bpo_pkg::KP_SHOW && pend_reg == src_reg[1];
    endproperty
    a_show: assert property (p_show)
        else $error("current source not shown");

endmodule : bpo_port

/* verilog/bpo_pkg.sv */
// constants, types and register map of the bcd pressure output port
package bpo_pkg;

    // clock and timing
    localparam int CLK_HZ       = 10_000_000;
    localparam int STROBE_NS    = 10_000;
    localparam int STROBE_CYC   =
        (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int UPDATE_MS    = 500;
    localparam int UPDATE_CYC   = UPDATE_MS * (CLK_HZ / 1000);
    localparam int PER_W        = 23;
    localparam int STR_W        = 7;

    // apb register byte offsets
    localparam logic [7:0] OFS_CMD     = 8'h00;
    localparam logic [7:0] OFS_SETTING = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_MASK    = 8'h0C;
    localparam logic [7:0] OFS_SAMPLE  = 8'h10;

    // command register fields
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_KEY_LSB  = 8;
    localparam logic [1:0] KEY_DIGITS = 2'h0;
    localparam logic [1:0] KEY_SELECT = 2'h1;
    localparam logic [1:0] KEY_ENTER  = 2'h2;

    // function codes
    localparam logic [4:0] FC_FACTORY = 5'h00;
    localparam logic [4:0] FC_SRC_G1  = 5'h05;
    localparam logic [4:0] FC_SRC_G2  = 5'h06;
    localparam logic [4:0] FC_TORR    = 5'h18;
    localparam logic [4:0] FC_MBAR    = 5'h19;
    localparam logic [4:0] FC_PASCAL  = 5'h1A;

    // setting register fields
    localparam int SET_UNIT_LSB = 0;
    localparam int SET_SRC1_LSB = 2;
    localparam int SET_SRC2_LSB = 4;
    localparam int SET_PEND_LSB = 6;
    localparam int SET_KP_LSB   = 8;

    // status and mask bits
    localparam int ST_UPDATE = 0;
    localparam int ST_HELD   = 1;
    localparam int ST_REJECT = 2;
    localparam int ST_W      = 3;
    localparam logic [ST_W-1:0] ST_RST = 3'h0;

    typedef enum logic [1:0] {
        UNIT_TORR = 2'h0,
        UNIT_MBAR = 2'h1,
        UNIT_PA   = 2'h2
    } bpo_unit_t;

    typedef enum logic [1:0] {
        SRC_ION  = 2'h0,
        SRC_CONV = 2'h1,
        SRC_SYS  = 2'h2,
        SRC_DISP = 2'h3
    } bpo_src_t;

    typedef enum logic [2:0] {
        KP_IDLE = 3'b001,
        KP_CODE = 3'b010,
        KP_SHOW = 3'b100
    } bpo_kp_t;

    // one pressure reading as it appears on the connector
    typedef struct packed {
        logic [3:0] units;
        logic [3:0] tenths;
        logic [3:0] hundredths;
        logic       exp_sign;
        logic       exp_tens;
        logic [3:0] exp_units;
        logic       active_gauge_type;
        logic       degas;
        logic       trouble;
    } bpo_press_t;

    localparam bpo_press_t PRESS_RST = '0;
    localparam bpo_press_t MAX_TORR  = '{4'h1, 4'h0, 4'h0, 1'b1, 1'b0,
                                        4'h3, 1'b0, 1'b0, 1'b0};
    localparam bpo_press_t MAX_MBAR  = '{4'h1, 4'h3, 4'h3, 1'b1, 1'b0,
                                        4'h3, 1'b0, 1'b0, 1'b0};
    localparam bpo_press_t MAX_PA    = '{4'h1, 4'h3, 4'h3, 1'b1, 1'b0,
                                        4'h5, 1'b0, 1'b0, 1'b0};

endpackage : bpo_pkg

/* sim/bpo_remote.sv */
// remote receiver model on the far side of the bcd connector
`timescale 1ns/100ps
module bpo_remote (
    input  wire logic                clock_i,
    input  wire bpo_pkg::bpo_press_t press_i,
    input  wire logic                press_oe_i,
    input  wire logic                strobe_i,
    input  wire logic [1:0]          drive_en_i,
    input  wire logic [1:0]          drive_val_i,
    output logic                     float_req_o,
    output logic                     hold_n_o,
    output bpo_pkg::bpo_press_t      word_o,
    output int                       n_words_o,
    output int                       high_len_o,
    output int                       bad_o
);
    bpo_pkg::bpo_press_t bus;
    bpo_pkg::bpo_press_t last = '0;
    bpo_pkg::bpo_press_t seen = '0;
    int                  run = 0;
    // released control lines read high through the pull-ups
    assign float_req_o = drive_en_i[0] ? drive_val_i[0] : 1'b1;
    assign hold_n_o    = drive_en_i[1] ? drive_val_i[1] : 1'b1;
    // a floated bus shows the inverse of what it last carried
    assign bus = press_oe_i ? press_i : ~last;
    initial
    begin
        word_o = '0;
        n_words_o = 0;
        high_len_o = 0;
        bad_o = 0;
    end
    // data is taken when the strobe falls, so it must be settled by then
    always @(posedge clock_i)
    begin
        if (press_oe_i)
            last <= press_i;
        if (press_i !== seen && strobe_i !== 1'b1)
            bad_o <= bad_o + 1;
        seen <= press_i;
        if (strobe_i === 1'b1)
            run <= run + 1;
        else if (run != 0)
        begin
            word_o <= bus;
            n_words_o <= n_words_o + 1;
            high_len_o <= run;
            run <= 0;
        end
    end
endmodule : bpo_remote

/* sim/bpo_port_bench.sv */
// self-checking bench of the bcd pressure output port
`timescale 1ns/100ps
module bpo_port_bench;
    typedef bpo_pkg::bpo_press_t pr_t;
    localparam pr_t P0 = '{4'h7, 4'h2, 4'h5, 1'b0, 1'b1, 4'h6, 1'b1, 1'b0, 1'b1};
    localparam pr_t P1 = '{4'h3, 4'h0, 4'h9, 1'b1, 1'b0, 4'h2, 1'b0, 1'b1, 1'b0};
    localparam pr_t P2 = '{4'h5, 4'h8, 4'h2, 1'b0, 1'b0, 4'h4, 1'b1, 1'b1, 1'b1};
    localparam pr_t PD = '{4'h4, 4'h4, 4'h1, 1'b0, 1'b0, 4'h8, 1'b0, 1'b0, 1'b0};
    localparam pr_t PC = '{4'h9, 4'h9, 4'h9, 1'b1, 1'b1, 4'h9, 1'b0, 1'b0, 1'b0};
    logic        clock_i, rst_b_i, psel_i, penable_i, pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rdata;
    logic        pready_o, pslverr_o, last_err, float_req_i, hold_n_i;
    logic        group_jumper_i, security_green_i, press_oe_o, strobe_o;
    logic [1:0]  drive_en, drive_val, ion_on;
    logic [2:0]  unit_ind_o;
    logic        irq_o;
    pr_t [1:0]   ion_press_i;
    pr_t         press_o, word, exp_src [4];
    int          n_words, high_len, bad, mismatches, n_tests, cycles, k;

    bpo_port #(.UPDATE_CYC(300)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .float_req_i(float_req_i), .hold_n_i(hold_n_i),
        .group_jumper_i(group_jumper_i), .security_green_i(security_green_i),
        .cg_installed_i(1'b0), .ion_gauge_on_i(ion_on),
        .ion_press_i(ion_press_i), .conv_press_i({PC, PC}),
        .disp_press_i({PD, PD}), .press_o(press_o), .press_oe_o(press_oe_o),
        .strobe_o(strobe_o), .unit_ind_o(unit_ind_o), .irq_o(irq_o));
    bpo_remote remote (.clock_i(clock_i), .press_i(press_o),
        .press_oe_i(press_oe_o), .strobe_i(strobe_o), .drive_en_i(drive_en),
        .drive_val_i(drive_val), .float_req_o(float_req_i),
        .hold_n_o(hold_n_i), .word_o(word), .n_words_o(n_words),
        .high_len_o(high_len), .bad_o(bad));

    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    always @(posedge clock_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk_pr(input pr_t got, input pr_t exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pr

    // setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        last_err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic cmd(input logic [1:0] key, input logic [4:0] code);
        apb(1'b1, bpo_pkg::OFS_CMD, {22'h0, key, 3'h0, code});
    endtask : cmd

    // returns setting with the pending field masked out
    task automatic rd_set();
        apb(1'b0, bpo_pkg::OFS_SETTING, 32'h0);
        rdata = rdata & 32'h0000073F;
    endtask : rd_set

    task automatic wait_words(input int n);
        n = n + n_words;
        while (n_words < n)
            @(posedge clock_i);
    endtask : wait_words

    initial
    begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {mismatches, n_tests, cycles} = '0;
        {group_jumper_i, rst_b_i} = 2'b00;
        security_green_i = 1'b1;
        drive_en = 2'b11;
        drive_val = 2'b10;
        ion_on = 2'b10;
        ion_press_i = {P1, P0};
        exp_src = '{P0, bpo_pkg::MAX_TORR, bpo_pkg::MAX_TORR, PD};
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd_set();
        chk32(rdata, 32'h100);
        chk32({29'h0, unit_ind_o}, 32'h1);
        for (int i = 1; i <= 3; i++)
        begin
            cmd(bpo_pkg::KEY_DIGITS, 5'(bpo_pkg::FC_TORR + i % 3));
            cmd(bpo_pkg::KEY_ENTER, 5'(bpo_pkg::FC_TORR + i % 3));
            rd_set();
            chk32(rdata, 32'h100 | (i % 3));
            chk32({29'h0, unit_ind_o}, 32'h1 << (i % 3));
        end
        security_green_i <= 1'b0;
        cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_MBAR);
        cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_MBAR);
        rd_set();
        chk32(rdata, 32'h100);
        apb(1'b1, bpo_pkg::OFS_MASK, 32'h4);
        @(negedge clock_i);
        chk32({31'h0, irq_o}, 32'h1);
        apb(1'b1, bpo_pkg::OFS_STATUS, 32'h4);
        @(negedge clock_i);
        chk32({31'h0, irq_o}, 32'h0);
        security_green_i <= 1'b1;
        // one select press per pass walks the source round and back to ion
        for (int s = 1; s <= 4; s++)
        begin
            cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_SRC_G1);
            cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_SRC_G1);
            cmd(bpo_pkg::KEY_SELECT, 5'h0);
            cmd(bpo_pkg::KEY_ENTER, 5'h0);
            rd_set();
            chk32(rdata, 32'h100 | ((s % 4) << 2));
            wait_words(2);
            chk_pr(word, exp_src[s % 4]);
        end
        chk32(32'(high_len), bpo_pkg::STROBE_CYC);
        cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_SRC_G1);
        cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_SRC_G1);
        cmd(bpo_pkg::KEY_SELECT, 5'h0);
        cmd(bpo_pkg::KEY_ENTER, 5'h0);
        cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_SRC_G2);
        cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_SRC_G2);
        cmd(bpo_pkg::KEY_SELECT, 5'h0);
        cmd(bpo_pkg::KEY_ENTER, 5'h0);
        rd_set();
        chk32(rdata, 32'h114);
        cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_FACTORY);
        cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_FACTORY);
        rd_set();
        chk32(rdata, 32'h100);
        cmd(bpo_pkg::KEY_DIGITS, bpo_pkg::FC_SRC_G1);
        cmd(bpo_pkg::KEY_ENTER, bpo_pkg::FC_SRC_G1);
        cmd(bpo_pkg::KEY_ENTER, 5'h0);
        rd_set();
        chk32(rdata, 32'h100);
        group_jumper_i <= 1'b1;
        wait_words(3);
        chk_pr(word, P1);
        drive_val <= 2'b00;
        repeat (10) @(posedge clock_i);
        ion_press_i[1] <= P2;
        repeat (700) @(posedge clock_i);
        chk_pr(press_o, P1);
        apb(1'b0, bpo_pkg::OFS_STATUS, 32'h0);
        chk32(rdata & 32'h2, 32'h2);
        drive_en <= 2'b01;
        wait_words(2);
        chk_pr(word, P2);
        drive_en <= 2'b00;
        repeat (8) @(posedge clock_i);
        chk32({31'h0, press_oe_o}, 32'h0);
        drive_en <= 2'b01;
        repeat (8) @(posedge clock_i);
        chk32({31'h0, press_oe_o}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk32({31'h0, last_err}, 32'h1);
        chk32(32'(bad), 32'h0);
        stop_test();
    end
endmodule : bpo_port_bench
